// File: padc_pkg.sv
// package: constants for the converter output port
package padc_pkg;
   localparam int unsigned DATA_W       = 12;
   localparam int unsigned LATENCY      = 6;
   localparam int unsigned FIFO_DEPTH   = 16;
   localparam int unsigned RAW_W        = 14;
   localparam logic [11:0] CODE_MIN     = 12'h000;
   localparam logic [11:0] CODE_MID     = 12'h800;
   localparam logic [11:0] CODE_MAX     = 12'hFFF;
   localparam logic [13:0] RAW_MID      = 14'h2000;
   localparam logic [13:0] RAW_LO_LIM   = 14'h1800;
   localparam logic [13:0] RAW_HI_LIM   = 14'h27FF;
   localparam logic [13:0] RAW_SE_LO    = 14'h1000;
   localparam logic [13:0] RAW_SE_HI    = 14'h2FFF;
   localparam int unsigned CLK_PERIOD_NS = 100;
endpackage : padc_pkg

// File: padc_fifo.sv
// file: parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module padc_fifo #(
   parameter int unsigned WIDTH = 12,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             rst_b_i,
   input  wire logic             flush_i,
   input  wire logic [WIDTH-1:0] in_data_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   output logic      [WIDTH-1:0] out_data_o,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   wire              push = in_valid_i && in_ready_o;
   wire              pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH)) && !flush_i;
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i || flush_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : padc_fifo
`default_nettype wire

// File: padc_core.sv
// file: digital side of the pipelined converter and its output port
//
// Notes on behaviour
// - one new output word every clock
// - sample on rising edge, nine-cycle latency from pin to data_o
// - results are 12-bit parallel words
// - output enable high tri-states data outputs
// - conversion continues while outputs tri-stated
// - sleep request high enters low power
// - differential codes are offset binary
// - single-ended codes rise linearly, quarter 0x400
// - over-range saturates at nearest extreme code
// - data valid only with enable and sleep low
// - sleep corrupts pipeline, outputs undefined
`timescale 1ns/100ps
`default_nettype none
module padc_core (
   input  wire logic                        clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic [padc_pkg::RAW_W-1:0]  raw_sample_i,
   input  wire logic                        single_ended_i,
   input  wire logic                        out_enable_b_i,
   input  wire logic                        sleep_request_i,
   output logic      [padc_pkg::DATA_W-1:0] data_o,
   output logic      [padc_pkg::DATA_W-1:0] data_oe_o,
   output logic                             data_valid_o,
   output logic                             low_power_o,
   output logic      [padc_pkg::DATA_W-1:0] fifo_data_o,
   output logic                             fifo_valid_o,
   input  wire logic                        fifo_ready_i,
   output logic                             fifo_overrun_o
);
   import padc_pkg::*;

   // raw tracks the driven input against common mode; a single-ended
   // drive swings twice as far, so its span is twice the differential one
   function automatic logic [DATA_W-1:0] to_code(
      input logic [RAW_W-1:0] raw,
      input logic             se
   );
      logic [RAW_W-1:0] lo;
      logic [RAW_W-1:0] hi;
      logic [RAW_W-1:0] sh;
      lo = se ? RAW_SE_LO : RAW_LO_LIM;
      hi = se ? RAW_SE_HI : RAW_HI_LIM;
      sh = raw - lo;
      if (raw <= lo) begin
         // clamp rather than wrap, so over-range pins the extreme code
         to_code = CODE_MIN;
      end else if (raw >= hi) begin
         to_code = CODE_MAX;
      end else if (se) begin
         sh = sh >> 1;
         to_code = sh[DATA_W-1:0];
      end else begin
         to_code = sh[DATA_W-1:0];
      end
   endfunction : to_code

   // pin inputs come from outside the clock domain
   logic [RAW_W-1:0] raw_s1_q, raw_s2_q;
   logic [2:0]       ctl_s1_q, ctl_s2_q;
   always_ff @(posedge clk_i) begin
      raw_s1_q <= raw_sample_i;
      raw_s2_q <= raw_s1_q;
      ctl_s1_q <= {single_ended_i, out_enable_b_i, sleep_request_i};
      ctl_s2_q <= ctl_s1_q;
   end
   wire se_w    = ctl_s2_q[2];
   wire oe_b_w  = ctl_s2_q[1];
   wire sleep_w = ctl_s2_q[0];

   wire [DATA_W-1:0] code_w = to_code(raw_s2_q, se_w);

   a_code_sat: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (!se_w && raw_s2_q >= RAW_HI_LIM) |-> code_w == CODE_MAX)
      else $error("over-range not saturated");
   a_code_floor: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (!se_w && raw_s2_q <= RAW_LO_LIM) |-> code_w == CODE_MIN)
      else $error("under-range not saturated");
   a_code_mid: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      raw_s2_q == RAW_MID |-> code_w == CODE_MID)
      else $error("zero input not mid code");
   a_se_ceiling: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (se_w && raw_s2_q >= RAW_SE_HI) |-> code_w == CODE_MAX)
      else $error("single-ended over-range not saturated");
   a_se_floor: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (se_w && raw_s2_q <= RAW_SE_LO) |-> code_w == CODE_MIN)
      else $error("single-ended under-range not saturated");
   a_code_monotone: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      ($stable(se_w) && raw_s2_q > $past(raw_s2_q)) |->
         code_w >= $past(code_w))
      else $error("code fell while input rose");

   // pipeline of LATENCY stages, always advancing
   logic [DATA_W-1:0]  pipe_q [LATENCY];
   logic [LATENCY-1:0] vld_q;
   always_ff @(posedge clk_i) begin
      pipe_q[0] <= sleep_w ? ~pipe_q[0] : code_w;
   end
   genvar g;
   generate
      for (g = 1; g < LATENCY; g++) begin : g_pipe
         // sleep scrambles stages, as the analog stages lose charge
         always_ff @(posedge clk_i) begin
            pipe_q[g] <= sleep_w ? ~pipe_q[g-1] : pipe_q[g-1];
         end
      end
   endgenerate

   // one valid bit per stage, so a wake refills before anything shows
   always_ff @(posedge clk_i) begin
      if (rst_b_i && !sleep_w) begin
         vld_q <= {vld_q[LATENCY-2:0], 1'b1};
      end else begin
         vld_q <= '0;
      end
   end

   wire [DATA_W-1:0] tail_w = pipe_q[LATENCY-1];
   wire              show_w = !oe_b_w && !sleep_w;

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         data_o       <= CODE_MID;
         data_oe_o    <= '0;
         data_valid_o <= 1'b0;
         low_power_o  <= 1'b0;
      end else begin
         data_o       <= tail_w;
         data_oe_o    <= {DATA_W{!oe_b_w}};
         data_valid_o <= show_w && vld_q[LATENCY-1];
         low_power_o  <= sleep_w;
      end
   end

   // words shown to the host also stream into the buffer
   wire fifo_in_ready_w;
   wire push_w = show_w && vld_q[LATENCY-1];
   padc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .flush_i     (sleep_w),
      .in_data_i   (tail_w),
      .in_valid_i  (push_w),
      .in_ready_o  (fifo_in_ready_w),
      .out_data_o  (fifo_data_o),
      .out_valid_o (fifo_valid_o),
      .out_ready_i (fifo_ready_i)
   );

   // the converter cannot stall, so a full buffer drops and flags it
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         fifo_overrun_o <= 1'b0;
      end else if (push_w && !fifo_in_ready_w) begin
         fifo_overrun_o <= 1'b1;
      end
   end

   a_latency_six: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (!sleep_w [*8]) |=> data_o == $past(code_w, 7))
      else $error("output word not six stages behind sample");
   a_valid_rate: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (vld_q[LATENCY-1] && show_w) |=>
         data_valid_o && data_o == $past(tail_w))
      else $error("shown word not delivered next clock");

   a_tristate_oe: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      oe_b_w |=> data_oe_o == '0)
      else $error("data driven while enable high");
   a_drive_on: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      !oe_b_w |=> data_oe_o == '1)
      else $error("data not driven while enable low");

   a_oe_keeps: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      (oe_b_w && !sleep_w) |=> vld_q[0] && pipe_q[0] == $past(code_w))
      else $error("pipeline stalled while tri-stated");
   a_oe_lost: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      oe_b_w |=> !data_valid_o)
      else $error("word marked valid while tri-stated");

   a_sleep_power: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      sleep_w |=> low_power_o && !data_valid_o)
      else $error("sleep not honoured");
   a_wake_power: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      !sleep_w |=> !low_power_o)
      else $error("low power held while awake");

   a_valid_gate: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      data_valid_o |-> !low_power_o && data_oe_o != '0)
      else $error("valid while disabled or asleep");

   a_refill_six: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      $fell(sleep_w) |-> !vld_q[LATENCY-1] [*6])
      else $error("stale word marked valid after sleep");
   a_wake_quiet: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      $fell(sleep_w) |-> !data_valid_o [*7])
      else $error("output valid during refill");
   a_sleep_flush: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      sleep_w |=> !fifo_valid_o)
      else $error("buffer not flushed by sleep");

   a_push_kept: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      push_w |=> fifo_valid_o || fifo_overrun_o)
      else $error("shown word neither buffered nor flagged");
   a_overrun_hold: assert property (@(posedge clk_i)
      disable iff (!rst_b_i)
      fifo_overrun_o |=> fifo_overrun_o)
      else $error("overrun flag cleared without reset");
endmodule : padc_core
`default_nettype wire

// File: padc_host_model.sv
// host model: latches words and drains the stream
`timescale 1ns/100ps
`default_nettype none
module padc_host_model
   import padc_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              stall_i,
   input  wire logic [DATA_W-1:0] data_i,
   input  wire logic              valid_i,
   input  wire logic              fifo_valid_i,
   output logic                   fifo_ready_o,
   output logic      [DATA_W-1:0] word_o,
   output int                     pops_o
);
   assign fifo_ready_o = !stall_i;
   initial pops_o = 0;
   // falling edge, where the driven word is stable
   always @(negedge clk_i) begin
      if (valid_i) word_o <= data_i;
   end
   always @(posedge clk_i) begin
      if (fifo_valid_i && fifo_ready_o) pops_o <= pops_o + 1;
   end
endmodule : padc_host_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for the converter output port
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import padc_pkg::*;
   logic              clk_i, rst_b_i = 0, se = 0, oe_b = 0;
   logic              sleep = 0, stall = 0;
   logic [RAW_W-1:0]  raw = RAW_MID;
   logic [DATA_W-1:0] dat, oe, fdat, word;
   logic              vld, lp, fvld, frdy, ovr;
   int                pops, err_count = 0, tests_run = 0;
   padc_core dut (.clk_i, .rst_b_i, .raw_sample_i(raw),
      .single_ended_i(se), .out_enable_b_i(oe_b),
      .sleep_request_i(sleep), .data_o(dat), .data_oe_o(oe),
      .data_valid_o(vld), .low_power_o(lp), .fifo_data_o(fdat),
      .fifo_valid_o(fvld), .fifo_ready_i(frdy), .fifo_overrun_o(ovr));
   padc_host_model host (.clk_i, .stall_i(stall), .data_i(dat),
      .valid_i(vld), .fifo_valid_i(fvld), .fifo_ready_o(frdy),
      .word_o(word), .pops_o(pops));
   // 10 MHz, inside the allowed band
   initial begin
      clk_i = 0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("[FAIL] %0t %s", $time, m);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_i);
   endtask : cyc
   task automatic t_stream;
      logic [RAW_W-1:0]  r[8] = '{14'h1800, 14'h1C00, 14'h2000,
         14'h2400, 14'h27FF, 14'h0000, 14'h3FFF, 14'h1801};
      logic [DATA_W-1:0] x[8] = '{12'h000, 12'h400, 12'h800,
         12'hC00, 12'hFFF, 12'h000, 12'hFFF, 12'h001};
      // new sample every clock, checked nine edges later
      for (int n = 0; n < 17; n++) begin
         @(negedge clk_i);
         if (n >= 9) chk(dat === x[n-9] && vld === 1'b1, "word");
         if (n < 8) raw = r[n];
      end
      chk(ovr === 1'b0, "no drop");
   endtask : t_stream
   task automatic t_oe;
      oe_b = 1;
      cyc(4);
      chk(oe === '0 && vld === 1'b0, "oe off");
      raw = 14'h2400;
      cyc(6);
      oe_b = 0;
      cyc(4);
      chk(oe === '1 && vld === 1'b1 && dat === 12'hC00, "oe on");
   endtask : t_oe
   task automatic t_sleep;
      sleep = 1;
      cyc(4);
      chk(lp === 1'b1 && vld === 1'b0, "sleep");
      sleep = 0;
      cyc(4);
      chk(vld === 1'b0, "refill");
      cyc(12);
      chk(lp === 1'b0 && vld === 1'b1 && dat === 12'hC00, "wake");
   endtask : t_sleep
   task automatic t_se;
      logic [RAW_W-1:0]  r[4] = '{14'h1000, 14'h1800, 14'h2800, 14'h3000};
      logic [DATA_W-1:0] x[4] = '{12'h000, 12'h400, 12'hC00, 12'hFFF};
      se = 1;
      for (int i = 0; i < 4; i++) begin
         raw = r[i];
         cyc(12);
         chk(word === x[i] && vld === 1'b1, "se code");
      end
      se = 0;
      cyc(12);
   endtask : t_se
   task automatic t_fifo;
      int p;
      stall = 1;
      cyc(30);
      chk(ovr === 1'b1 && fvld === 1'b1, "full");
      // stop pushes first so the drain count is exact
      oe_b = 1;
      cyc(8);
      chk(fdat === CODE_MAX && fvld === 1'b1, "fifo word");
      p = pops;
      stall = 0;
      cyc(30);
      chk(pops - p == FIFO_DEPTH && fvld === 1'b0, "drain");
      oe_b = 0;
   endtask : t_fifo
   task automatic t_reset;
      rst_b_i = 0;
      cyc(2);
      chk(dat === CODE_MID && oe === '0 && vld === 1'b0 && lp === 1'b0
         && ovr === 1'b0 && fvld === 1'b0, "reset");
      rst_b_i = 1;
      cyc(12);
      chk(vld === 1'b1 && dat === CODE_MAX && ovr === 1'b0, "rerun");
   endtask : t_reset
   task automatic print_verdict;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      cyc(16);
      rst_b_i = 1;
      cyc(12);
      t_stream();
      t_oe();
      t_sleep();
      t_se();
      t_fifo();
      t_reset();
      print_verdict();
   end
   // about 220 cycles expected, so 4000 is ample
   initial begin
      #400000;
      err_count++;
      print_verdict();
   end
endmodule : testbench
`default_nettype wire
